// ### rtl/aapc_top.sv
// Auxiliary pin control: configuration register and pin drivers.
// Assumes a register port from the serial interface, the converter core
// giving channel switch pulses, and a pad ring resolving output enables.

// Functional notes
// RL1 - Config register at 0x06, reset 0x0800
// RL2 - Reserved top bit written zero, reads zero
// RL3 - Power-down switch bit turns sink on
// RL4 - Output-only pins driven only when enabled; A is also driven whenever mux mode is on
// RL5 - Mux mode drives select lines per channel
// RL6 - Channel input pair still applied
// RL7 - Host reselects input pair every eight
// RL8 - Sync low holds converter and filter reset
// RL9 - Alternate sync blocks start at switch
// RL10 - Error mode 00 off, 01 input
// RL11 - Open-drain mode pulls low on error
// RL12 - Mode 11 push-pull follows data bit
// RL13 - Error data bit drives or reads pin
// RL14 - Bits 7, 6 write-only output data
// RL15 - Bit 5 enables bidir B input
// RL16 - Bits 4,3,2 input/output enables
// RL17 - Bits 1,0 bidir data, read pin level
// RL18 - Disabled pins undriven, write-only reads zero
module aapc_top (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_alternate_sync_mode,
  input wire logic i_multi_channel,
  input wire logic i_channel_switch,
  input wire logic [2:0] i_channel_index,
  input wire logic i_status_error,
  input wire logic i_sync_pin,
  input wire logic i_error_pin,
  input wire logic i_bidir_a_pin,
  input wire logic i_bidir_b_pin,
  output logic o_converter_hold,
  output logic o_conversion_start_block,
  output logic o_adc_error,
  output logic o_power_down_switch_on,
  output logic o_out_only_a_pin,
  output logic o_out_only_a_pin_oe_n,
  output logic o_out_only_b_pin,
  output logic o_out_only_b_pin_oe_n,
  output logic o_bidir_a_pin,
  output logic o_bidir_a_pin_oe_n,
  output logic o_bidir_b_pin,
  output logic o_bidir_b_pin_oe_n,
  output logic o_error_pin,
  output logic o_error_pin_oe_n
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cfg;
    logic [2:0] mux_sel;
    logic waiting;
    logic [15:0] rdata;
    logic rvalid;
    logic hold;
    logic block;
    logic adc_err;
    logic power_down_switch_en;
    logic oa;
    logic oa_oe_n;
    logic ob;
    logic ob_oe_n;
    logic ba;
    logic ba_oe_n;
    logic bb;
    logic bb_oe_n;
    logic ep;
    logic ep_oe_n;
  } aapc_state_t;

  aapc_state_t state_reg;
  aapc_state_t state_next;

  aapc_pin_if pin_if ();

  aapc_pin_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_pins({i_sync_pin, i_error_pin, i_bidir_b_pin, i_bidir_a_pin}),
    .pin_if(pin_if.sync_side)
  );

  // ----------------------------------------------------------------------
  // Read-back value
  // ----------------------------------------------------------------------
  function automatic logic [15:0] read_value(input logic [15:0] cfg, input logic ea,
                                             input logic eb, input logic ee);
    logic [15:0] v;
    v = cfg;
    v[aapc_pkg::RESERVED_BIT] = 1'b0; // RL2
    v[aapc_pkg::OUT_ONLY_B_DATA] = 1'b0; // RL18
    v[aapc_pkg::OUT_ONLY_A_DATA] = 1'b0; // RL14
    if (cfg[aapc_pkg::ERR_MODE_HI:aapc_pkg::ERR_MODE_LO] == aapc_pkg::ERR_MODE_INPUT) begin
      v[aapc_pkg::ERROR_PIN_DATA] = ee; // RL13
    end
    // Pin level is shown only while the input path is enabled
    if (cfg[aapc_pkg::BIDIR_A_INPUT_EN]) begin
      v[aapc_pkg::BIDIR_A_DATA] = ea; // RL17
    end
    if (cfg[aapc_pkg::BIDIR_B_INPUT_EN]) begin
      v[aapc_pkg::BIDIR_B_DATA] = eb; // RL15
    end
    return v;
  endfunction : read_value

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic [15:0] c;
  logic [1:0] emode;
  logic mux_on;
  logic sync_on;

  always_comb begin
    state_next = state_reg;
    c = state_reg.cfg;
    if (i_reg_wr && i_reg_addr == aapc_pkg::AUX_PIN_CONFIG_ADDR) begin
      c = i_reg_wdata & aapc_pkg::AUX_PIN_CONFIG_WMASK; // RL1 RL2
    end
    state_next.cfg = c;
    emode = c[aapc_pkg::ERR_MODE_HI:aapc_pkg::ERR_MODE_LO];
    mux_on = c[aapc_pkg::EXT_MUX_CTRL_EN];
    sync_on = c[aapc_pkg::SYNC_INPUT_EN];

    state_next.rvalid = i_reg_rd;
    if (i_reg_rd && i_reg_addr == aapc_pkg::AUX_PIN_CONFIG_ADDR) begin
      state_next.rdata = read_value(state_reg.cfg, pin_if.bidir_a_level,
                                    pin_if.bidir_b_level, pin_if.error_level);
    end else if (i_reg_rd) begin
      state_next.rdata = 16'h0000;
    end

    // Selects follow the channel the core switches to; the host handles each group of eight
    if (i_channel_switch) begin
      state_next.mux_sel = i_channel_index; // RL5 RL7
    end

    // Normal sync resets at once; alternate sync only blocks the next start
    state_next.hold = sync_on && !(i_alternate_sync_mode && i_multi_channel) &&
                      !pin_if.sync_level; // RL8
    if (!(sync_on && i_alternate_sync_mode && i_multi_channel) || pin_if.sync_level) begin
      state_next.waiting = 1'b0;
    end else if (i_channel_switch) begin
      state_next.waiting = 1'b1; // RL9
    end
    state_next.block = state_next.waiting;

    state_next.adc_err = emode == aapc_pkg::ERR_MODE_INPUT && !pin_if.error_level; // RL10

    state_next.power_down_switch_en = c[aapc_pkg::POWER_DOWN_SWITCH_EN]; // RL3

    // Output-only pins; A doubles as select bit 2 in mux mode
    state_next.oa_oe_n = !(c[aapc_pkg::OUT_ONLY_PINS_EN] || mux_on); // RL4 RL18
    state_next.ob_oe_n = !c[aapc_pkg::OUT_ONLY_PINS_EN]; // RL4
    state_next.oa = mux_on ? state_next.mux_sel[2] : c[aapc_pkg::OUT_ONLY_A_DATA]; // RL14
    state_next.ob = c[aapc_pkg::OUT_ONLY_B_DATA]; // RL14

    // Bidirectional pins, taken over as select bits 0 and 1 in mux mode
    state_next.ba_oe_n = !(c[aapc_pkg::BIDIR_A_OUTPUT_EN] || mux_on); // RL16 RL18
    state_next.bb_oe_n = !(c[aapc_pkg::BIDIR_B_OUTPUT_EN] || mux_on); // RL16 RL18
    state_next.ba = mux_on ? state_next.mux_sel[0] : c[aapc_pkg::BIDIR_A_DATA]; // RL5 RL17
    state_next.bb = mux_on ? state_next.mux_sel[1] : c[aapc_pkg::BIDIR_B_DATA]; // RL5 RL17

    // Error pin: open drain only ever drives low, so several parts may share a pull-up
    case (emode)
      aapc_pkg::ERR_MODE_OPEN_DRAIN: begin
        state_next.ep = 1'b0;
        state_next.ep_oe_n = !i_status_error; // RL11
      end
      aapc_pkg::ERR_MODE_GP_OUT: begin
        state_next.ep = c[aapc_pkg::ERROR_PIN_DATA]; // RL12 RL13
        state_next.ep_oe_n = 1'b0;
      end
      default: begin
        state_next.ep = 1'b0;
        state_next.ep_oe_n = 1'b1; // RL10 RL18
      end
    endcase
  end

  // Channel pair selection stays in the core and is never overridden here
  // RL6

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= '0;
      state_reg.cfg <= aapc_pkg::AUX_PIN_CONFIG_RESET; // RL1
      state_reg.oa_oe_n <= 1'b1;
      state_reg.ob_oe_n <= 1'b1;
      state_reg.ba_oe_n <= 1'b1;
      state_reg.bb_oe_n <= 1'b1;
      state_reg.ep_oe_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_reg_rdata = state_reg.rdata;
  assign o_reg_rvalid = state_reg.rvalid;
  assign o_converter_hold = state_reg.hold;
  assign o_conversion_start_block = state_reg.block;
  assign o_adc_error = state_reg.adc_err;
  assign o_power_down_switch_on = state_reg.power_down_switch_en;
  assign o_out_only_a_pin = state_reg.oa;
  assign o_out_only_a_pin_oe_n = state_reg.oa_oe_n;
  assign o_out_only_b_pin = state_reg.ob;
  assign o_out_only_b_pin_oe_n = state_reg.ob_oe_n;
  assign o_bidir_a_pin = state_reg.ba;
  assign o_bidir_a_pin_oe_n = state_reg.ba_oe_n;
  assign o_bidir_b_pin = state_reg.bb;
  assign o_bidir_b_pin_oe_n = state_reg.bb_oe_n;
  assign o_error_pin = state_reg.ep;
  assign o_error_pin_oe_n = state_reg.ep_oe_n;

endmodule : aapc_top

// ### rtl/aapc_pkg.sv
// Package for the auxiliary pin control block: register address, field
// positions, reset value and enumerations.
// Assumes a 16-bit register port with an address and write/read strobes.
package aapc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] AUX_PIN_CONFIG_ADDR = 8'h06;
  localparam logic [15:0] AUX_PIN_CONFIG_RESET = 16'h0800;
  localparam logic [15:0] AUX_PIN_CONFIG_WMASK = 16'h7fff;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int RESERVED_BIT = 15;
  localparam int POWER_DOWN_SWITCH_EN = 14;
  localparam int OUT_ONLY_PINS_EN = 13;
  localparam int EXT_MUX_CTRL_EN = 12;
  localparam int SYNC_INPUT_EN = 11;
  localparam int ERR_MODE_HI = 10;
  localparam int ERR_MODE_LO = 9;
  localparam int ERROR_PIN_DATA = 8;
  localparam int OUT_ONLY_B_DATA = 7;
  localparam int OUT_ONLY_A_DATA = 6;
  localparam int BIDIR_B_INPUT_EN = 5;
  localparam int BIDIR_A_INPUT_EN = 4;
  localparam int BIDIR_B_OUTPUT_EN = 3;
  localparam int BIDIR_A_OUTPUT_EN = 2;
  localparam int BIDIR_B_DATA = 1;
  localparam int BIDIR_A_DATA = 0;

  // ----------------------------------------------------------------------
  // Error pin modes
  // ----------------------------------------------------------------------
  localparam logic [1:0] ERR_MODE_OFF = 2'h0;
  localparam logic [1:0] ERR_MODE_INPUT = 2'h1;
  localparam logic [1:0] ERR_MODE_OPEN_DRAIN = 2'h2;
  localparam logic [1:0] ERR_MODE_GP_OUT = 2'h3;

  localparam int MUX_SEL_WIDTH = 3;

endpackage : aapc_pkg

// ### rtl/aapc_pin_if.sv
// Interface carrying sampled pin levels from the synchroniser to the core.
// Assumes both ends run on the converter clock.
interface aapc_pin_if;
  logic bidir_a_level;
  logic bidir_b_level;
  logic error_level;
  logic sync_level;
  modport sync_side (output bidir_a_level, output bidir_b_level, output error_level,
    output sync_level);
  modport core_side (input bidir_a_level, input bidir_b_level, input error_level,
    input sync_level);
endinterface : aapc_pin_if

// ### rtl/aapc_pin_sync.sv
// Three-stage synchroniser for the four pin inputs.
// Assumes asynchronous pins; a level is taken once stages two and three agree.
module aapc_pin_sync (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_pins,
  aapc_pin_if.sync_side pin_if
);

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] level;
  } aapc_sync_t;

  aapc_sync_t state_reg;
  aapc_sync_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.s1 = i_pins;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    for (int i = 0; i < 4; i++) begin
      // Only a stable pair of later stages updates the level, filtering one-cycle glitches
      if (state_reg.s2[i] == state_reg.s3[i]) begin
        state_next.level[i] = state_reg.s3[i];
      end
    end
  end

  // Sync and error pins reset to their idle high level: no hold and no false error at start-up
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= '{s1: 4'hc, s2: 4'hc, s3: 4'hc, level: 4'hc};
    end else begin
      state_reg <= state_next;
    end
  end

  assign pin_if.bidir_a_level = state_reg.level[0];
  assign pin_if.bidir_b_level = state_reg.level[1];
  assign pin_if.error_level = state_reg.level[2];
  assign pin_if.sync_level = state_reg.level[3];

endmodule : aapc_pin_sync

// ### dv/aapc_top_monitor.sv
// Checker bound to the auxiliary pin control top.
// Assumes register effects show one cycle after the write edge.
module aapc_top_monitor (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic o_converter_hold,
  input wire logic o_power_down_switch_on,
  input wire logic o_out_only_b_pin_oe_n,
  input wire logic o_error_pin,
  input wire logic o_error_pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic wr6;
  assign wr6 = i_reg_wr && (i_reg_addr == aapc_pkg::AUX_PIN_CONFIG_ADDR);
  read_answer_a: assert property (i_reg_rd |=> o_reg_rvalid) else $error("read unanswered");
  unmapped_zero_a: assert property (i_reg_rd && !wr6 && i_reg_addr != 8'h06 |=>
    o_reg_rdata == 16'h0000) else $error("unmapped read not zero");
  reserved_zero_a: assert property (o_reg_rvalid |->
    o_reg_rdata[15] == 1'b0 && o_reg_rdata[7:6] == 2'h0) else $error("bit not zero");
  switch_bit_a: assert property (wr6 |=>
    o_power_down_switch_on == $past(i_reg_wdata[14])) else $error("switch wrong");
  out_only_en_a: assert property (wr6 |=>
    o_out_only_b_pin_oe_n == !$past(i_reg_wdata[13])) else $error("enable wrong");
  err_off_a: assert property (wr6 && i_reg_wdata[10:9] == 2'h0 |=> o_error_pin_oe_n)
    else $error("error pin driven");
  err_drain_a: assert property (wr6 && i_reg_wdata[10:9] == 2'h2 |=> !o_error_pin)
    else $error("drain level high");
  err_gp_out_a: assert property (wr6 && i_reg_wdata[10:9] == 2'h3 |=>
    !o_error_pin_oe_n && o_error_pin == $past(i_reg_wdata[8])) else $error("output wrong");
  sync_off_a: assert property (wr6 && !i_reg_wdata[11] ##1 !i_reg_wr |=>
    !o_converter_hold) else $error("hold while sync off");
endmodule : aapc_top_monitor

bind aapc_top aapc_top_monitor i_mon (.i_ref_clk, .i_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr,
  .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .o_converter_hold, .o_power_down_switch_on,
  .o_out_only_b_pin_oe_n, .o_error_pin, .o_error_pin_oe_n);

// ### dv/aapc_far_model.sv
// Far side of the pins: outside drivers and the shared error pull-up.
// Assumes the bench sets what outside parts drive.
module aapc_far_model (
  input wire logic i_a,
  input wire logic i_a_oe_n,
  input wire logic i_b,
  input wire logic i_b_oe_n,
  input wire logic i_err,
  input wire logic i_err_oe_n,
  input wire logic i_ext_a,
  input wire logic i_ext_b,
  input wire logic i_ext_err_low,
  output logic o_a,
  output logic o_b,
  output logic o_err
);
  timeunit 1ns;
  timeprecision 1ps;
  assign o_a = !i_a_oe_n ? i_a : i_ext_a;
  assign o_b = !i_b_oe_n ? i_b : i_ext_b;
  // Pull-up wins when nobody sinks, so a wired line of several parts reads high
  assign o_err = (!i_err_oe_n ? i_err : 1'b1) & !i_ext_err_low;
endmodule : aapc_far_model

// ### dv/aapc_top_tb.sv
// Testbench for the auxiliary pin control top.
// Assumes pin inputs settle through the synchroniser within six edges.
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module aapc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, wr = 0, rd = 0, alt = 0, multi = 0, sw = 0, serr = 0, sync = 1;
  logic ea = 0, eb = 0, elow = 0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wd = 16'h0000, rdat;
  logic [2:0] idx = 3'h0;
  logic rv, hold, blk, aerr, pds, oa, oa_n, ob, ob_n, ba, ba_n, bb, bb_n, ep, ep_n, pa, pb, pe;
  int failures = 0;
  int compares = 0;
  aapc_top i_aapc_top (.i_ref_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_rvalid(rv),
    .i_alternate_sync_mode(alt), .i_multi_channel(multi), .i_channel_switch(sw),
    .i_channel_index(idx), .i_status_error(serr), .i_sync_pin(sync), .i_error_pin(pe),
    .i_bidir_a_pin(pa), .i_bidir_b_pin(pb), .o_converter_hold(hold),
    .o_conversion_start_block(blk), .o_adc_error(aerr), .o_power_down_switch_on(pds),
    .o_out_only_a_pin(oa), .o_out_only_a_pin_oe_n(oa_n), .o_out_only_b_pin(ob),
    .o_out_only_b_pin_oe_n(ob_n), .o_bidir_a_pin(ba), .o_bidir_a_pin_oe_n(ba_n),
    .o_bidir_b_pin(bb), .o_bidir_b_pin_oe_n(bb_n), .o_error_pin(ep), .o_error_pin_oe_n(ep_n));
  aapc_far_model i_aapc_far_model (.i_a(ba), .i_a_oe_n(ba_n), .i_b(bb), .i_b_oe_n(bb_n),
    .i_err(ep), .i_err_oe_n(ep_n), .i_ext_a(ea), .i_ext_b(eb), .i_ext_err_low(elow),
    .o_a(pa), .o_b(pb), .o_err(pe));
  initial forever #20 clk = ~clk;
  task automatic end_of_test;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  task automatic wreg(logic [7:0] a, logic [15:0] d);
    addr = a; wd = d; wr = 1; tick(1); wr = 0; tick(1);
  endtask : wreg
  // Read answer is waited for under a bound, as its latency is the design's choice
  task automatic rreg(logic [7:0] a, logic [15:0] e);
    int i;
    addr = a; rd = 1; tick(1); rd = 0;
    for (i = 0; i < 3 && rv !== 1'b1; i++) tick(1);
    if (i == 3) begin
      failures++;
      end_of_test();
    end else begin
      `CHK(rdat, e)
      // One idle edge keeps back-to-back reads from toggling the strobe in one step
      tick(1);
    end
  endtask : rreg
  task automatic t_regs;
    rreg(8'h06, 16'h0800);
    `CHK({ba_n, bb_n, oa_n, ob_n, ep_n, pds}, 6'h3e)
    wreg(8'h06, 16'h60cf);
    `CHK({pds, oa, oa_n, ob, ob_n}, 5'h1a)
    `CHK({ba, ba_n, bb, bb_n}, 4'ha)
    rreg(8'h06, 16'h600f);
    wreg(8'h07, 16'h0000);
    rreg(8'h05, 16'h0000);
    rreg(8'h06, 16'h600f);
    wreg(8'h06, 16'h0000);
    `CHK({pds, oa_n, ob_n, ba_n, bb_n}, 5'h0f)
    $display("register test done");
  endtask : t_regs
  task automatic t_bidir;
    ea = 1; eb = 0; wreg(8'h06, 16'h0030); tick(5);
    rreg(8'h06, 16'h0031);
    ea = 0; eb = 1; tick(5);
    rreg(8'h06, 16'h0032);
    $display("bidir test done");
  endtask : t_bidir
  task automatic t_err;
    wreg(8'h06, 16'h0100);
    `CHK(ep_n, 1'b1)
    elow = 1; wreg(8'h06, 16'h0300); tick(5);
    `CHK({aerr, ep_n}, 2'h3)
    rreg(8'h06, 16'h0200);
    elow = 0; tick(5);
    `CHK(aerr, 1'b0)
    rreg(8'h06, 16'h0300);
    serr = 1; wreg(8'h06, 16'h0400);
    `CHK({ep, ep_n, pe}, 3'h0)
    serr = 0; tick(2);
    `CHK({ep_n, pe}, 2'h3)
    wreg(8'h06, 16'h0700);
    `CHK({ep, ep_n}, 2'h2)
    wreg(8'h06, 16'h0600);
    `CHK({ep, ep_n}, 2'h0)
    $display("error pin test done");
  endtask : t_err
  task automatic t_mux;
    wreg(8'h06, 16'h1000);
    for (int i = 0; i < 8; i++) begin
      idx = i[2:0]; sw = 1; tick(1); sw = 0; tick(1);
      `CHK({oa, bb, ba, oa_n, bb_n, ba_n}, {idx, 3'h0})
    end
    // Eight channels done: the host rewrites the config register with mux mode still on
    wreg(8'h06, 16'h1000);
    $display("mux test done");
  endtask : t_mux
  task automatic t_sync;
    wreg(8'h06, 16'h0800); sync = 0; tick(6);
    `CHK(hold, 1'b1)
    sync = 1; tick(6);
    `CHK(hold, 1'b0)
    alt = 1; multi = 1; sync = 0; tick(6);
    `CHK({hold, blk}, 2'h0)
    sw = 1; tick(1); sw = 0; tick(1);
    `CHK(blk, 1'b1)
    sync = 1; tick(6);
    `CHK(blk, 1'b0)
    alt = 0; multi = 0; sync = 0;
    wreg(8'h06, 16'h0000); tick(6);
    `CHK({hold, blk}, 2'h0)
    sync = 1; tick(6);
    $display("sync test done");
  endtask : t_sync
  initial begin
    tick(20);
    rst = 0;
    tick(1);
    t_regs(); t_bidir(); t_err(); t_mux(); t_sync();
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule : aapc_top_tb
